// file: rtl/sacs_pkg.sv
package sacs_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] CHAN_OFF = 8'h04;
    localparam logic [7:0] TRIG_OFF = 8'h08;
    localparam logic [7:0] DATA_OFF = 8'h0C;

    // control field positions within the write word
    localparam int START_BIT = 6;
    localparam int DONE_BIT = 4;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] CHAN_RST = 2'h0;
    localparam logic [2:0] TRIG_RST = 3'h0;
    localparam logic [7:0] DATA_RST = 8'h00;

    // conversion timing in converter half cycles
    localparam logic [5:0] NORM_HOLD = 6'h07;
    localparam logic [5:0] NORM_END = 6'h1A;
    localparam logic [5:0] FIRST_HOLD = 6'h21;
    localparam logic [5:0] FIRST_END = 6'h32;
    localparam logic [5:0] AUTO_HOLD = 6'h08;
    localparam logic [5:0] AUTO_END = 6'h1B;

    // trigger synchroniser depth in system clocks
    localparam int SYNC_STAGES = 3;

    // successive approximation
    localparam logic [7:0] SAR_MSB = 8'h80;
    localparam logic [7:0] RESULT_SAT = 8'hFF;

    // trigger source code meaning free running
    localparam logic [2:0] TRIG_FREE = 3'h0;

    // sleep mode codes reported by the core
    localparam logic [1:0] SLP_IDLE = 2'h0;
    localparam logic [1:0] SLP_NOISE = 2'h1;

    typedef struct packed {
        logic enable;
        logic start;
        logic auto_trig;
        logic done;
        logic irq_en;
        logic [2:0] div_sel;
    } sacs_ctrl_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } sacs_state_t;

    typedef enum logic [1:0] {
        K_NORM = 2'b00,
        K_FIRST = 2'b01,
        K_AUTO = 2'b10
    } sacs_kind_t;

endpackage

// file: rtl/sacs_seq.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module sacs_seq (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic [7:0] i_trig_flags,
    input wire logic i_cpu_halt,
    input wire logic [1:0] i_sleep_mode,
    input wire logic i_cmp_ge,
    input wire logic i_over_ref,
    output logic [7:0] o_dac_code,
    output logic [1:0] o_chan,
    output logic o_sample_hold,
    output logic o_conv_busy,
    output logic o_adc_clk,
    output logic o_irq_req
);

    // half period of the converter clock in system clocks
    function automatic logic [6:0] div_half(input logic [2:0] sel);
        logic [6:0] h;
        h = 7'h01;
        unique case (sel)
            3'h0, 3'h1: h = 7'h01;
            3'h2: h = 7'h02;
            3'h3: h = 7'h04;
            3'h4: h = 7'h08;
            3'h5: h = 7'h10;
            3'h6: h = 7'h20;
            3'h7: h = 7'h40;
        endcase
        return h;
    endfunction

    // hold point or end point of a conversion kind
    function automatic logic [5:0] conv_lim(input sacs_pkg::sacs_kind_t k,
                                            input logic is_end);
        logic [5:0] v;
        v = sacs_pkg::NORM_HOLD;
        unique case (k)
            sacs_pkg::K_NORM:
                v = is_end ? sacs_pkg::NORM_END : sacs_pkg::NORM_HOLD;
            sacs_pkg::K_FIRST:
                v = is_end ? sacs_pkg::FIRST_END : sacs_pkg::FIRST_HOLD;
            sacs_pkg::K_AUTO:
                v = is_end ? sacs_pkg::AUTO_END : sacs_pkg::AUTO_HOLD;
            default: v = sacs_pkg::NORM_HOLD;
        endcase
        return v;
    endfunction

    sacs_pkg::sacs_ctrl_t ctrl_ff;
    sacs_pkg::sacs_ctrl_t nxt_ctrl;
    logic [1:0] chan_tmp_ff;
    logic [1:0] chan_ff;
    logic [2:0] trig_sel_ff;
    logic [7:0] data_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [6:0] pre_cnt_ff;
    logic phase_ff;
    logic trig_prev_ff;
    logic [sacs_pkg::SYNC_STAGES-1:0] trig_pipe_ff;
    sacs_pkg::sacs_state_t state_ff;
    sacs_pkg::sacs_kind_t kind_ff;
    logic [5:0] half_ff;
    logic first_pend_ff;
    logic en_prev_ff;
    logic halt_prev_ff;
    logic [7:0] code_ff;
    logic [7:0] mask_ff;
    logic sat_ff;
    logic hold_ff;
    logic busy_ff;
    logic irq_ff;

    logic acc;
    logic wr;
    logic wr_ctrl;
    logic tick;
    logic rise;
    logic free_run;
    logic trig_sig;
    logic trig_edge;
    logic trig_fire;
    logic conv_tick;
    logic complete;
    logic start_single;
    logic sleep_start;
    logic [5:0] hold_lim;
    logic [5:0] end_lim;
    logic addr_ok;
    logic first_now;

    // bus decode; access phase only counts once pready is up
    assign acc = i_psel && i_penable && pready_ff;
    assign wr = acc && i_pwrite;
    assign wr_ctrl = wr && (i_paddr == sacs_pkg::CTRL_OFF);
    assign addr_ok = (i_paddr == sacs_pkg::CTRL_OFF) ||
                     (i_paddr == sacs_pkg::CHAN_OFF) ||
                     (i_paddr == sacs_pkg::TRIG_OFF) ||
                     (i_paddr == sacs_pkg::DATA_OFF);

    // prescaler edges; >= so a smaller divider never waits for a wrap
    assign tick = ctrl_ff.enable && !trig_fire &&
                  (pre_cnt_ff >= div_half(ctrl_ff.div_sel) - 7'h01);
    // enable rising in this cycle already counts as first
    assign first_now = first_pend_ff || (ctrl_ff.enable && !en_prev_ff);
    assign rise = tick && !phase_ff;
    assign free_run = ctrl_ff.auto_trig &&
                      (trig_sel_ff == sacs_pkg::TRIG_FREE);
    assign trig_sig = i_trig_flags[trig_sel_ff];
    // edges while busy or already in the synchroniser are dropped
    assign trig_edge = ctrl_ff.enable && ctrl_ff.auto_trig &&
                       (trig_sel_ff != sacs_pkg::TRIG_FREE) &&
                       trig_sig && !trig_prev_ff &&
                       (state_ff == sacs_pkg::ST_IDLE) &&
                       (trig_pipe_ff == '0);
    assign trig_fire = trig_pipe_ff[sacs_pkg::SYNC_STAGES-1];
    assign hold_lim = conv_lim(kind_ff, 1'b0);
    assign end_lim = conv_lim(kind_ff, 1'b1);
    assign conv_tick = (state_ff == sacs_pkg::ST_CONV) && tick;
    assign complete = conv_tick && (half_ff == end_lim - 6'h01);
    assign start_single = (state_ff == sacs_pkg::ST_IDLE) &&
                          ctrl_ff.start && rise;
    // idle or noise reduction sleep start on the halt edge
    assign sleep_start = ctrl_ff.enable && !ctrl_ff.start &&
                         (state_ff == sacs_pkg::ST_IDLE) &&
                         !ctrl_ff.auto_trig && ctrl_ff.irq_en &&
                         i_cpu_halt && !halt_prev_ff &&
                         ((i_sleep_mode == sacs_pkg::SLP_IDLE) ||
                          (i_sleep_mode == sacs_pkg::SLP_NOISE));

    // next control value: software writes, hardware sets and clears
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl.enable = i_pwdata[7];
            nxt_ctrl.auto_trig = i_pwdata[5];
            nxt_ctrl.irq_en = i_pwdata[3];
            nxt_ctrl.div_sel = i_pwdata[2:0];
            if (i_pwdata[sacs_pkg::START_BIT]) begin
                nxt_ctrl.start = 1'b1; // zero writes leave it
            end
            if (i_pwdata[sacs_pkg::DONE_BIT]) begin
                nxt_ctrl.done = 1'b0;
            end
        end
        if (sleep_start || trig_fire) begin
            nxt_ctrl.start = 1'b1;
        end
        if (complete) begin
            nxt_ctrl.done = 1'b1; // set beats a same-cycle clear
            if (!free_run) begin
                nxt_ctrl.start = 1'b0;
            end
        end
        if (!nxt_ctrl.enable) begin
            nxt_ctrl.start = 1'b0;
        end
    end

    // control register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_ff <= sacs_pkg::CTRL_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // plain software registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            chan_tmp_ff <= sacs_pkg::CHAN_RST;
            trig_sel_ff <= sacs_pkg::TRIG_RST;
        end else if (wr) begin
            if (i_paddr == sacs_pkg::CHAN_OFF) begin
                chan_tmp_ff <= i_pwdata[1:0];
            end
            if (i_paddr == sacs_pkg::TRIG_OFF) begin
                trig_sel_ff <= i_pwdata[2:0];
            end
        end
    end

    // apb answer: no wait state, every output registered from the setup cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= i_psel && !i_penable;
            pslverr_ff <= i_psel && !i_penable && !addr_ok;
            prdata_ff <= 32'h0000_0000;
            if (i_psel && !i_penable && !i_pwrite) begin
                unique case (i_paddr)
                    sacs_pkg::CTRL_OFF: prdata_ff[7:0] <= ctrl_ff;
                    sacs_pkg::CHAN_OFF: prdata_ff[1:0] <= chan_tmp_ff;
                    sacs_pkg::TRIG_OFF: prdata_ff[2:0] <= trig_sel_ff;
                    sacs_pkg::DATA_OFF: prdata_ff[7:0] <= data_ff;
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // prescaler, reset while disabled and on each trigger
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pre_cnt_ff <= 7'h00;
            phase_ff <= 1'b0;
        end else if (!ctrl_ff.enable || trig_fire) begin
            pre_cnt_ff <= 7'h00;
            phase_ff <= 1'b0;
        end else if (tick) begin
            pre_cnt_ff <= 7'h00;
            phase_ff <= !phase_ff; // divide by twice the half period
        end else begin
            pre_cnt_ff <= pre_cnt_ff + 7'h01;
        end
    end

    // trigger edge detect and three-cycle synchroniser
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trig_prev_ff <= 1'b0;
            trig_pipe_ff <= '0;
        end else begin
            trig_prev_ff <= trig_sig;
            trig_pipe_ff <= {trig_pipe_ff[sacs_pkg::SYNC_STAGES-2:0],
                             trig_edge};
        end
    end

    // first conversion marker armed on enable rising
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_prev_ff <= 1'b0;
            first_pend_ff <= 1'b0;
            halt_prev_ff <= 1'b0;
        end else begin
            en_prev_ff <= ctrl_ff.enable;
            halt_prev_ff <= i_cpu_halt;
            if (start_single || trig_fire) begin
                first_pend_ff <= 1'b0;
            end else if (ctrl_ff.enable && !en_prev_ff) begin
                first_pend_ff <= 1'b1;
            end
        end
    end

    // conversion sequencer counting converter half cycles
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= sacs_pkg::ST_IDLE;
            kind_ff <= sacs_pkg::K_NORM;
            half_ff <= 6'h00;
        end else if (!ctrl_ff.enable) begin
            state_ff <= sacs_pkg::ST_IDLE; // abort
            half_ff <= 6'h00;
        end else begin
            unique case (state_ff)
                sacs_pkg::ST_IDLE: begin
                    half_ff <= 6'h00;
                    if (trig_fire) begin
                        state_ff <= sacs_pkg::ST_CONV;
                        kind_ff <= first_now ? sacs_pkg::K_FIRST
                                             : sacs_pkg::K_AUTO;
                    end else if (start_single) begin
                        state_ff <= sacs_pkg::ST_CONV;
                        kind_ff <= first_now ? sacs_pkg::K_FIRST
                                             : sacs_pkg::K_NORM;
                    end
                end
                sacs_pkg::ST_CONV: begin
                    if (complete) begin
                        half_ff <= 6'h00;
                        if (free_run) begin
                            kind_ff <= sacs_pkg::K_NORM;
                        end else begin
                            state_ff <= sacs_pkg::ST_IDLE;
                        end
                    end else if (conv_tick) begin
                        half_ff <= half_ff + 6'h01;
                    end
                end
            endcase
        end
    end

    // active channel tracks the temporary one outside the locked span
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            chan_ff <= sacs_pkg::CHAN_RST;
        end else if (ctrl_ff.enable) begin
            if (state_ff == sacs_pkg::ST_IDLE) begin
                chan_ff <= chan_tmp_ff;
            end else if (half_ff >= end_lim - 6'h02 && !complete) begin
                chan_ff <= chan_tmp_ff;
            end
            // otherwise frozen, so a free-running restart keeps it
        end
    end

    // sample, then eight successive approximation steps
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            code_ff <= 8'h00;
            mask_ff <= 8'h00;
            sat_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            hold_ff <= 1'b0;
            if (conv_tick && half_ff == hold_lim - 6'h01) begin
                hold_ff <= 1'b1;
                sat_ff <= i_over_ref;
                code_ff <= sacs_pkg::SAR_MSB;
                mask_ff <= sacs_pkg::SAR_MSB;
            end else if (conv_tick && half_ff >= hold_lim &&
                         mask_ff != 8'h00) begin
                code_ff <= (i_cmp_ge ? code_ff : (code_ff & ~mask_ff)) |
                           (mask_ff >> 1);
                mask_ff <= mask_ff >> 1;
            end
        end
    end

    // result register written in the same step as the done flag
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            data_ff <= sacs_pkg::DATA_RST;
        end else if (complete) begin
            data_ff <= sat_ff ? sacs_pkg::RESULT_SAT : code_ff;
        end
    end

    // status outputs; request follows the flag whatever woke the cpu
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            busy_ff <= (state_ff == sacs_pkg::ST_CONV);
            irq_ff <= nxt_ctrl.done && nxt_ctrl.irq_en;
        end
    end
    // sleep modes other than idle and noise reduction are not seen here

    assign o_pready = pready_ff;
    assign o_prdata = prdata_ff;
    assign o_pslverr = pslverr_ff;
    assign o_dac_code = code_ff;
    assign o_chan = chan_ff;
    assign o_sample_hold = hold_ff;
    assign o_conv_busy = busy_ff;
    assign o_adc_clk = phase_ff;
    assign o_irq_req = irq_ff;

endmodule // sacs_seq

// file: verif/sacs_analog_model.sv
`timescale 1ns/1ps
module sacs_analog_model (
    input wire logic i_clk,
    input wire logic i_sample_hold,
    input wire logic [1:0] i_chan,
    input wire logic [7:0] i_dac_code,
    input wire logic [3:0][8:0] i_level,
    output logic o_cmp_ge,
    output logic o_over_ref
);
    logic [8:0] held;
    // capacitor keeps the level of the channel at the hold pulse
    initial held = 9'h000;
    always @(posedge i_clk) begin
        if (i_sample_hold) begin
            held <= i_level[i_chan];
        end
    end
    // levels above 0xFF stand for inputs at or over the reference
    // during the hold pulse the capacitor still follows the input
    assign o_cmp_ge = ((i_sample_hold ? i_level[i_chan] : held) >=
                       {1'b0, i_dac_code});
    assign o_over_ref = i_level[i_chan][8];
endmodule // sacs_analog_model

// file: verif/sacs_seq_props.sv
`timescale 1ns/1ps
module sacs_seq_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic [1:0] o_chan,
    input wire logic o_sample_hold,
    input wire logic o_conv_busy,
    input wire logic o_irq_req
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // bus answers in the first access cycle, for one cycle only
    pready_timing_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("ready missing after setup");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    slverr_unmapped_a: assert property (i_psel && !i_penable
        && i_paddr > 8'h0C |=> o_pslverr) else $error("no error on hole");
    slverr_mapped_a: assert property (i_psel && !i_penable
        && i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0C} |=> !o_pslverr)
        else $error("error on mapped word");
    prdata_upper_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // hold pulse is short and only inside a conversion
    sample_pulse_a: assert property (o_sample_hold |=> !o_sample_hold)
        else $error("hold pulse too long");
    sample_busy_a: assert property (o_sample_hold |-> o_conv_busy)
        else $error("hold pulse while idle");
    sample_bound_a: assert property ($rose(o_conv_busy)
        |-> ##[1:1000] o_sample_hold) else $error("no hold pulse");
    chan_frozen_a: assert property ($rose(o_conv_busy)
        |=> $stable(o_chan) [*4]) else $error("channel moved");
    // reset must quiet the block at the very next edge
    reset_quiet_a: assert property (@(posedge i_clk) disable iff (1'b0)
        i_rst |=> !o_conv_busy && !o_irq_req && !o_pready)
        else $error("outputs live after reset");
endmodule // sacs_seq_props

bind sacs_seq sacs_seq_props sacs_seq_props_i (.i_clk(i_clk),
    .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_chan(o_chan), .o_sample_hold(o_sample_hold),
    .o_conv_busy(o_conv_busy), .o_irq_req(o_irq_req));

// file: verif/sar_adc_conversion_sequencer_test.sv
`timescale 1ns/1ps
module sar_adc_conversion_sequencer_test;
    typedef struct {logic [2:0] dv; logic [1:0] ch; logic [8:0] lv;} sacs_row_t;
    logic i_clk, i_rst, psel, pen, pwr, halt, cmp, ovr, rerr;
    logic pready, pslverr, shold, busy, aclk, irq;
    logic [7:0] paddr, trig, dac;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] smode, chan;
    logic [3:0][8:0] level;
    int err_total, tests_run, n;
    sacs_row_t rows [8] = '{'{3'h0, 2'h1, 9'h05A}, '{3'h1, 2'h2, 9'h0FF},
        '{3'h2, 2'h3, 9'h100}, '{3'h3, 2'h0, 9'h000}, '{3'h4, 2'h1, 9'h1FF},
        '{3'h5, 2'h2, 9'h0A5}, '{3'h6, 2'h3, 9'h080}, '{3'h7, 2'h0, 9'h07F}};

    sacs_seq sacs_seq_i (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_trig_flags(trig), .i_cpu_halt(halt), .i_sleep_mode(smode),
        .i_cmp_ge(cmp), .i_over_ref(ovr), .o_dac_code(dac), .o_chan(chan),
        .o_sample_hold(shold), .o_conv_busy(busy), .o_adc_clk(aclk),
        .o_irq_req(irq));
    sacs_analog_model sacs_analog_model_i (.i_clk(i_clk),
        .i_sample_hold(shold), .i_chan(chan), .i_dac_code(dac),
        .i_level(level), .o_cmp_ge(cmp), .o_over_ref(ovr));

    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;

    function automatic logic ok(input logic c);
        tests_run++;
        return c;
    endfunction
    task automatic fail(input string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // request held until ready is seen, released only after that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge i_clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) fail("no ready");
        rd = prdata;
        rerr = pslverr;
        {psel, pen} <= 2'b00;
    endtask
    // irq rises on the same edge as the flag; two edges are skipped first
    task automatic wait_irq(output int c);
        c = 2;
        repeat (2) @(negedge i_clk);
        while (irq !== 1'b1 && c < 4000) begin
            @(negedge i_clk);
            c++;
        end
    endtask
    task automatic conv(input logic [2:0] dv, input logic [1:0] ch,
                        input logic [8:0] lv, input int cyc);
        int c, dw;
        dw = (dv == 3'h0) ? 2 : (1 << dv);
        level[ch] <= lv;
        apb(1'b1, sacs_pkg::CHAN_OFF, {30'h0, ch});
        apb(1'b1, sacs_pkg::CTRL_OFF, {24'h0, 5'h1B, dv});
        wait_irq(c);
        if (!ok(c >= cyc * dw && c <= (cyc + 1) * dw + 4)) fail("length");
        apb(1'b0, sacs_pkg::CTRL_OFF, 32'h0);
        if (!ok(rd[6] === 1'b0 && rd[4] === 1'b1)) fail("start/done");
        apb(1'b0, sacs_pkg::DATA_OFF, 32'h0);
        if (!ok(rd[7:0] === (lv[8] ? 8'hFF : lv[7:0]))) fail("result");
    endtask

    initial begin
        {i_rst, psel, pen, pwr, halt, paddr, pwdata} = {5'b10000, 40'h0};
        {trig, smode, level} = '0;
        {err_total, tests_run} = '0;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        // all words read zero after reset, hole flags an error
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            if (!ok(rd === 32'h0 && aclk === 1'b0)) fail("reset value");
        end
        apb(1'b0, 8'h10, 32'h0);
        if (!ok(rerr === 1'b1 && rd === 32'h0)) fail("hole");
        conv(3'h2, 2'h0, 9'h0C3, 25);
        foreach (rows[i]) conv(rows[i].dv, rows[i].ch, rows[i].lv, 13);
        // channel written mid-conversion, zero written to start
        level[1] <= 9'h011;
        level[2] <= 9'h022;
        apb(1'b1, sacs_pkg::CHAN_OFF, 32'h1);
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'hDB);
        repeat (8) @(posedge i_clk);
        apb(1'b1, sacs_pkg::CHAN_OFF, 32'h2);
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'h8B);
        if (!ok(chan === 2'h1)) fail("channel not frozen");
        apb(1'b0, sacs_pkg::CTRL_OFF, 32'h0);
        if (!ok(rd[6] === 1'b1)) fail("start lost");
        wait_irq(n);
        apb(1'b0, sacs_pkg::DATA_OFF, 32'h0);
        if (!ok(rd[7:0] === 8'h11 && chan === 2'h2)) fail("chan");
        // abort after the hold pulse by clearing enable
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'hDB);
        n = 0;
        while (shold !== 1'b1 && n < 500) begin
            @(negedge i_clk);
            n++;
        end
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'h0);
        repeat (300) @(posedge i_clk);
        if (!ok(busy === 1'b0 && irq === 1'b0)) fail("no abort");
        // sleep start, woken early; sleep mode 2 starts nothing
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'h9A);
        {smode, halt} <= 3'b011;
        repeat (5) @(posedge i_clk);
        halt <= 1'b0;
        wait_irq(n);
        if (!ok(irq === 1'b1)) fail("no sleep conversion");
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'h9A);
        {smode, halt} <= 3'b101;
        repeat (100) @(posedge i_clk);
        if (!ok(busy === 1'b0)) fail("wrong sleep start");
        halt <= 1'b0;
        // free running: channel change lands one conversion late
        level[0] <= 9'h040;
        level[1] <= 9'h080;
        apb(1'b1, sacs_pkg::CHAN_OFF, 32'h0);
        apb(1'b1, sacs_pkg::TRIG_OFF, 32'h0);
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'hFA);
        wait_irq(n);
        apb(1'b1, sacs_pkg::CHAN_OFF, 32'h1);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, sacs_pkg::CTRL_OFF, 32'hBA);
            wait_irq(n);
            apb(1'b0, sacs_pkg::DATA_OFF, 32'h0);
            if (!ok(rd[7:0] === (k ? 8'h80 : 8'h40))) fail("free run");
        end
        apb(1'b0, sacs_pkg::CTRL_OFF, 32'h0);
        if (!ok(rd[6] === 1'b1)) fail("start dropped");
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'h0);
        // auto trigger: third edge measured from flag to hold pulse
        apb(1'b1, sacs_pkg::TRIG_OFF, 32'h1);
        apb(1'b1, sacs_pkg::CTRL_OFF, 32'hBA);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            trig <= 8'h02;
            n = 0;
            do begin
                @(negedge i_clk);
                n++;
            end while (shold !== 1'b1 && n < 300);
            wait_irq(n);
            trig <= 8'h00;
            apb(1'b1, sacs_pkg::CTRL_OFF, 32'hBA);
        end
        if (!ok(irq !== 1'b1 || n < 4000)) fail("auto done");
        @(posedge i_clk);
        trig <= 8'h02;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (shold !== 1'b1 && n < 300);
        if (!ok(n >= 18 && n <= 23)) fail("trigger to hold");
        stop_test();
    end

    // whole run is well under sixty thousand cycles
    initial begin
        repeat (60000) @(posedge i_clk);
        fail("watchdog");
        stop_test();
    end
endmodule // sar_adc_conversion_sequencer_test
